// ---- rtl/ruc_core.sv ----
`timescale 1ns/1ps
module ruc_core (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic osc_tick,
	input wire logic [7:0] ad_in,
	output logic [7:0] ad_out,
	output logic ad_oe,
	input wire logic addr_strobe,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	output logic square_out,
	output logic irq_n_out,
	output logic irq_n_oe
);
	logic [6:0] addr_reg;
	logic as_prev_reg, wr_n_prev_reg, rd_act_reg;
	logic [7:0] rdata, rdata_reg;
	logic [7:0] user_reg [0:ruc_pkg::USER_BYTES-1];
	logic [7:0] ram_reg [0:ruc_pkg::RAM_BYTES-1];
	logic [6:0] ram_idx;
	logic [6:0] ctrl_a_reg;
	logic [7:0] ctrl_b_reg;
	logic update_pending_reg;
	logic periodic_flag_reg, alarm_match_flag_reg, update_done_flag_reg, irq_summary_flag_reg;
	logic [ruc_pkg::DIV_W-1:0] div_cnt_reg;
	logic tap_prev_reg, square_out_reg, irq_oe_reg;
	ruc_pkg::ruc_time_t int_time_reg;
	ruc_pkg::ruc_upd_state_t upd_state_reg;
	logic rd_act, wr_stb, rd_end, clr_flags, tick_1hz;
	logic [3:0] rate_select, tap_idx;
	logic tap_val, ev_periodic, ev_alarm, ev_update, alarm_hit;
	logic freeze_user_copy, periodic_irq_enable, alarm_irq_enable, update_irq_enable;
	logic square_out_enable, number_format_select, hour_format_select;
	logic periodic_flag_next, alarm_flag_next, update_flag_next, summary_next, irq_req;

	ruc_time_if tif ();

	assign rate_select = ctrl_a_reg[3:0];
	assign freeze_user_copy = ctrl_b_reg[ruc_pkg::B_FREEZE_BIT];
	assign periodic_irq_enable = ctrl_b_reg[ruc_pkg::B_PERIODIC_EN_BIT];
	assign alarm_irq_enable = ctrl_b_reg[ruc_pkg::B_ALARM_EN_BIT];
	assign update_irq_enable = ctrl_b_reg[ruc_pkg::B_UPDATE_EN_BIT];
	assign square_out_enable = ctrl_b_reg[ruc_pkg::B_SQUARE_EN_BIT];
	assign number_format_select = ctrl_b_reg[ruc_pkg::B_NUMBER_FMT_BIT];
	assign hour_format_select = ctrl_b_reg[ruc_pkg::B_HOUR_FMT_BIT];

	// -------------------------------------------------------------
	// multiplexed host bus
	// -------------------------------------------------------------
	// strobes are taken as synchronous; edges are found against the last sample
	assign rd_act = !cs_n && !rd_n;
	assign wr_stb = !wr_n_prev_reg && wr_n && !cs_n;
	assign rd_end = rd_act_reg && !rd_act;
	assign ram_idx = 7'(addr_reg - ruc_pkg::ADDR_RAM_BASE);
	assign ad_oe = rd_act;
	assign ad_out = rdata_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			as_prev_reg <= 1'b0;
			wr_n_prev_reg <= 1'b1;
			rd_act_reg <= 1'b0;
			addr_reg <= 7'h00;
			rdata_reg <= 8'h00;
		end else begin
			as_prev_reg <= addr_strobe;
			wr_n_prev_reg <= wr_n;
			rd_act_reg <= rd_act;
			rdata_reg <= rdata;
			if (as_prev_reg && !addr_strobe) begin
				addr_reg <= ad_in[6:0];
			end
		end
	end

	always_comb begin
		rdata = 8'h00;
		if (addr_reg < 7'(ruc_pkg::USER_BYTES)) begin
			rdata = user_reg[addr_reg[3:0]];
		end else if (addr_reg == ruc_pkg::ADDR_CTRL_A) begin
			rdata = {update_pending_reg, ctrl_a_reg};
		end else if (addr_reg == ruc_pkg::ADDR_CTRL_B) begin
			rdata = ctrl_b_reg;
		end else if (addr_reg == ruc_pkg::ADDR_CTRL_C) begin
			rdata = {irq_summary_flag_reg, periodic_flag_reg, alarm_match_flag_reg,
				update_done_flag_reg, 4'h0};
		end else if (addr_reg == ruc_pkg::ADDR_CTRL_D) begin
			rdata = ruc_pkg::CTRL_D_VALUE;
		end else begin
			rdata = ram_reg[ram_idx];
		end
	end

	// -------------------------------------------------------------
	// control registers and storage
	// -------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_reg <= ruc_pkg::CTRL_A_RESET;
			ctrl_b_reg <= ruc_pkg::CTRL_B_RESET;
		end else if (wr_stb && addr_reg == ruc_pkg::ADDR_CTRL_A) begin
			ctrl_a_reg <= ad_in[6:0];
		end else if (wr_stb && addr_reg == ruc_pkg::ADDR_CTRL_B) begin
			ctrl_b_reg <= ad_in;
		end
	end

	// storage is not reset: it models battery-held contents
	always_ff @(posedge core_clk) begin
		if (wr_stb && addr_reg >= ruc_pkg::ADDR_RAM_BASE) begin
			ram_reg[ram_idx] <= ad_in;
		end
	end

	// -------------------------------------------------------------
	// time base divider and rate selector
	// -------------------------------------------------------------
	assign tick_1hz = osc_tick && div_cnt_reg == ruc_pkg::DIV_LAST;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg <= '0;
		end else if (osc_tick) begin
			div_cnt_reg <= div_cnt_reg + 1'b1;
		end
	end

	// codes 1 and 2 alias onto the 256 Hz and 128 Hz taps
	always_comb begin
		if (rate_select >= ruc_pkg::RATE_FIRST_DIRECT) begin
			tap_idx = rate_select - ruc_pkg::RATE_DIRECT_SHIFT;
		end else begin
			tap_idx = rate_select + ruc_pkg::RATE_ALIAS_SHIFT;
		end
	end

	assign tap_val = (rate_select != 4'h0) && div_cnt_reg[tap_idx];
	// a rate change mid-period may give one short first interval
	assign ev_periodic = tap_prev_reg && !tap_val;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tap_prev_reg <= 1'b0;
			square_out_reg <= 1'b0;
		end else begin
			tap_prev_reg <= tap_val;
			square_out_reg <= square_out_enable && tap_val;
		end
	end
	assign square_out = square_out_reg;

	// -------------------------------------------------------------
	// update cycle
	// -------------------------------------------------------------
	assign tif.cur = int_time_reg;
	assign tif.bin_mode = number_format_select;
	assign tif.h24_mode = hour_format_select;

	ruc_time_adv u_adv (
		.t(tif)
	);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			upd_state_reg <= ruc_pkg::RUC_IDLE;
		end else begin
			unique case (upd_state_reg)
				ruc_pkg::RUC_IDLE: begin
					if (tick_1hz) begin
						upd_state_reg <= ruc_pkg::RUC_ADVANCE;
					end
				end
				ruc_pkg::RUC_ADVANCE: upd_state_reg <= ruc_pkg::RUC_FINISH;
				ruc_pkg::RUC_FINISH: upd_state_reg <= ruc_pkg::RUC_IDLE;
				default: upd_state_reg <= ruc_pkg::RUC_IDLE;
			endcase
		end
	end

	// host writes win over the advance so a set time is never lost
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_time_reg <= ruc_pkg::TIME_RESET;
		end else begin
			if (upd_state_reg == ruc_pkg::RUC_ADVANCE) begin
				int_time_reg <= tif.nxt;
			end
			if (wr_stb) begin
				unique case (addr_reg)
					ruc_pkg::ADDR_SECONDS_COUNT: int_time_reg.sec <= ad_in;
					ruc_pkg::ADDR_MINUTES_COUNT: int_time_reg.min <= ad_in;
					ruc_pkg::ADDR_HOURS_COUNT: int_time_reg.hour <= ad_in;
					ruc_pkg::ADDR_WEEKDAY_COUNT: int_time_reg.wday <= ad_in;
					ruc_pkg::ADDR_MONTHDAY_COUNT: int_time_reg.mday <= ad_in;
					ruc_pkg::ADDR_MONTH_COUNT: int_time_reg.mon <= ad_in;
					ruc_pkg::ADDR_YEAR_COUNT: int_time_reg.year <= ad_in;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < ruc_pkg::USER_BYTES; i++) begin
				user_reg[i] <= 8'h00;
			end
		end else begin
			if (upd_state_reg == ruc_pkg::RUC_FINISH && !freeze_user_copy) begin
				user_reg[0] <= int_time_reg.sec;
				user_reg[2] <= int_time_reg.min;
				user_reg[4] <= int_time_reg.hour;
				user_reg[6] <= int_time_reg.wday;
				user_reg[7] <= int_time_reg.mday;
				user_reg[8] <= int_time_reg.mon;
				user_reg[9] <= int_time_reg.year;
			end
			if (wr_stb && addr_reg < 7'(ruc_pkg::USER_BYTES)) begin
				user_reg[addr_reg[3:0]] <= ad_in;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			update_pending_reg <= 1'b0;
		end else begin
			update_pending_reg <= !freeze_user_copy &&
				(div_cnt_reg >= ruc_pkg::PENDING_START ||
				upd_state_reg == ruc_pkg::RUC_ADVANCE);
		end
	end

	// -------------------------------------------------------------
	// alarm compare and event flags
	// -------------------------------------------------------------
	assign alarm_hit = (user_reg[1][7:6] == ruc_pkg::MATCH_DONT_CARE ||
		user_reg[1] == int_time_reg.sec) &&
		(user_reg[3][7:6] == ruc_pkg::MATCH_DONT_CARE ||
		user_reg[3] == int_time_reg.min) &&
		(user_reg[5][7:6] == ruc_pkg::MATCH_DONT_CARE ||
		user_reg[5] == int_time_reg.hour);
	assign ev_update = upd_state_reg == ruc_pkg::RUC_FINISH;
	assign ev_alarm = ev_update && alarm_hit;
	assign clr_flags = rd_end && addr_reg == ruc_pkg::ADDR_CTRL_C;

	// a new event beats the read-clear in the same cycle
	assign periodic_flag_next = ev_periodic || (periodic_flag_reg && !clr_flags);
	assign alarm_flag_next = ev_alarm || (alarm_match_flag_reg && !clr_flags);
	assign update_flag_next = ev_update || (update_done_flag_reg && !clr_flags);
	assign irq_req = (ev_periodic && periodic_irq_enable) ||
		(ev_alarm && alarm_irq_enable) ||
		(ev_update && update_irq_enable && !freeze_user_copy);
	assign summary_next = irq_req || (irq_summary_flag_reg && !clr_flags);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			periodic_flag_reg <= 1'b0;
			alarm_match_flag_reg <= 1'b0;
			update_done_flag_reg <= 1'b0;
			irq_summary_flag_reg <= 1'b0;
			irq_oe_reg <= 1'b0;
		end else begin
			periodic_flag_reg <= periodic_flag_next;
			alarm_match_flag_reg <= alarm_flag_next;
			update_done_flag_reg <= update_flag_next;
			irq_summary_flag_reg <= summary_next;
			irq_oe_reg <= (periodic_flag_next && periodic_irq_enable) ||
				(alarm_flag_next && alarm_irq_enable) ||
				(update_flag_next && update_irq_enable && !freeze_user_copy);
		end
	end
	assign irq_n_out = 1'b0;
	assign irq_n_oe = irq_oe_reg;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_tick_update;
		tick_1hz && upd_state_reg == ruc_pkg::RUC_IDLE |=>
			upd_state_reg == ruc_pkg::RUC_ADVANCE ##1 upd_state_reg == ruc_pkg::RUC_FINISH;
	endproperty
	a_tick_update: assert property (p_tick_update) else $error("update cycle not run");

	property p_pending_end;
		ev_update |=> !update_pending_reg && update_done_flag_reg;
	endproperty
	a_pending_end: assert property (p_pending_end) else $error("pending or done wrong");

	property p_freeze_clears;
		freeze_user_copy |=> !update_pending_reg;
	endproperty
	a_freeze_clears: assert property (p_freeze_clears) else $error("pending while frozen");

	property p_freeze_holds;
		ev_update && freeze_user_copy && !wr_stb |=> $stable(user_reg[0]);
	endproperty
	a_freeze_holds: assert property (p_freeze_holds) else $error("host copy moved");

	property p_transfer;
		ev_update && !freeze_user_copy && !wr_stb |=> user_reg[0] == $past(int_time_reg.sec);
	endproperty
	a_transfer: assert property (p_transfer) else $error("no transfer");

	property p_square_off;
		!square_out_enable |=> !square_out;
	endproperty
	a_square_off: assert property (p_square_off) else $error("square out not low");

	property p_periodic_irq;
		ev_periodic && periodic_irq_enable |=> irq_n_oe && irq_summary_flag_reg;
	endproperty
	a_periodic_irq: assert property (p_periodic_irq) else $error("periodic irq missed");

	property p_read_clear;
		clr_flags && !ev_periodic && !ev_update |=>
			!periodic_flag_reg && !update_done_flag_reg && !irq_summary_flag_reg &&
			!alarm_match_flag_reg && !irq_n_oe;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("flags not cleared");

	property p_alarm_any;
		ev_update && user_reg[1][7:6] == 2'h3 && user_reg[3][7:6] == 2'h3 &&
			user_reg[5][7:6] == 2'h3 |=> alarm_match_flag_reg;
	endproperty
	a_alarm_any: assert property (p_alarm_any) else $error("dont care alarm missed");

	property p_update_gate;
		ev_update && freeze_user_copy && !irq_summary_flag_reg && !ev_periodic && !ev_alarm
			|=> !irq_summary_flag_reg;
	endproperty
	a_update_gate: assert property (p_update_gate) else $error("frozen update irq");

	c_periodic: cover property (ev_periodic ##1 irq_n_oe);
	c_alarm: cover property (ev_alarm);
	c_read_clear: cover property (clr_flags && irq_summary_flag_reg);
	c_frozen_update: cover property (ev_update && freeze_user_copy);
endmodule : ruc_core

// ---- rtl/ruc_pkg.sv ----
package ruc_pkg;
	// -------------------------------------------------------------
	// address map
	// -------------------------------------------------------------
	localparam int CLOCK_BYTES = 14;
	localparam int RAM_BYTES = 114;
	localparam int USER_BYTES = 10;
	localparam logic [6:0] ADDR_SECONDS_COUNT = 7'h00;
	localparam logic [6:0] ADDR_SECONDS_MATCH = 7'h01;
	localparam logic [6:0] ADDR_MINUTES_COUNT = 7'h02;
	localparam logic [6:0] ADDR_MINUTES_MATCH = 7'h03;
	localparam logic [6:0] ADDR_HOURS_COUNT = 7'h04;
	localparam logic [6:0] ADDR_HOURS_MATCH = 7'h05;
	localparam logic [6:0] ADDR_WEEKDAY_COUNT = 7'h06;
	localparam logic [6:0] ADDR_MONTHDAY_COUNT = 7'h07;
	localparam logic [6:0] ADDR_MONTH_COUNT = 7'h08;
	localparam logic [6:0] ADDR_YEAR_COUNT = 7'h09;
	localparam logic [6:0] ADDR_CTRL_A = 7'h0a;
	localparam logic [6:0] ADDR_CTRL_B = 7'h0b;
	localparam logic [6:0] ADDR_CTRL_C = 7'h0c;
	localparam logic [6:0] ADDR_CTRL_D = 7'h0d;
	localparam logic [6:0] ADDR_RAM_BASE = 7'h0e;
	// -------------------------------------------------------------
	// control field positions
	// -------------------------------------------------------------
	localparam int A_PENDING_BIT = 7;
	localparam int B_FREEZE_BIT = 7;
	localparam int B_PERIODIC_EN_BIT = 6;
	localparam int B_ALARM_EN_BIT = 5;
	localparam int B_UPDATE_EN_BIT = 4;
	localparam int B_SQUARE_EN_BIT = 3;
	localparam int B_NUMBER_FMT_BIT = 2;
	localparam int B_HOUR_FMT_BIT = 1;
	localparam int C_SUMMARY_BIT = 7;
	localparam int C_PERIODIC_BIT = 6;
	localparam int C_ALARM_BIT = 5;
	localparam int C_UPDATE_BIT = 4;
	// -------------------------------------------------------------
	// reset values
	// -------------------------------------------------------------
	localparam logic [6:0] CTRL_A_RESET = 7'h00;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;
	localparam logic [7:0] CTRL_D_VALUE = 8'h80;
	localparam logic [1:0] MATCH_DONT_CARE = 2'h3;
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] wday;
		logic [7:0] mday;
		logic [7:0] mon;
		logic [7:0] year;
	} ruc_time_t;
	// midnight, sunday, first of january, year 00, in bcd 12-hour form
	localparam ruc_time_t TIME_RESET = '{8'h00, 8'h00, 8'h12, 8'h01, 8'h01, 8'h01, 8'h00};
	// -------------------------------------------------------------
	// time base
	// -------------------------------------------------------------
	localparam int OSC_HZ = 32768;
	localparam int DIV_W = 15;
	localparam logic [DIV_W-1:0] DIV_LAST = 15'h7fff;
	localparam int PENDING_LEAD_US = 244;
	localparam int PENDING_LEAD_TICKS = (PENDING_LEAD_US * OSC_HZ + 999999) / 1000000;
	localparam logic [DIV_W-1:0] PENDING_START = 15'(OSC_HZ - PENDING_LEAD_TICKS);
	localparam logic [3:0] RATE_FIRST_DIRECT = 4'h3;
	localparam logic [3:0] RATE_DIRECT_SHIFT = 4'h2;
	localparam logic [3:0] RATE_ALIAS_SHIFT = 4'h5;
	typedef enum logic [1:0] {
		RUC_IDLE = 2'b00,
		RUC_ADVANCE = 2'b01,
		RUC_FINISH = 2'b10
	} ruc_upd_state_t;
endpackage : ruc_pkg

// ---- rtl/ruc_time_adv.sv ----
`timescale 1ns/1ps
module ruc_time_adv (
	ruc_time_if.adv t
);
	function automatic logic [7:0] dec(input logic [7:0] v, input logic bin);
		dec = bin ? v : 8'(8'(v[7:4]) * 8'd10 + 8'(v[3:0]));
	endfunction : dec

	function automatic logic [7:0] enc(input logic [7:0] v, input logic bin);
		enc = bin ? v : {4'(v / 8'd10), 4'(v % 8'd10)};
	endfunction : enc

	// -------------------------------------------------------------
	// one-second advance with carries
	// -------------------------------------------------------------
	always_comb begin
		logic [7:0] s, m, h, wd, md, mo, yr, dim, h12, hx;
		s = 8'(dec(t.cur.sec, t.bin_mode) + 8'd1);
		m = dec(t.cur.min, t.bin_mode);
		wd = dec(t.cur.wday, t.bin_mode);
		md = dec(t.cur.mday, t.bin_mode);
		mo = dec(t.cur.mon, t.bin_mode);
		yr = dec(t.cur.year, t.bin_mode);
		hx = 8'h00;
		h = 8'h00;
		h12 = 8'h00;
		dim = 8'd31;
		if (t.h24_mode) begin
			h = dec(t.cur.hour, t.bin_mode);
		end else begin
			h12 = dec({1'b0, t.cur.hour[6:0]}, t.bin_mode);
			h = (h12 == 8'd12) ? 8'h00 : h12;
			if (t.cur.hour[7]) begin
				h = 8'(h + 8'd12);
			end
		end
		// years 00..99: every fourth year is a leap year
		unique case (mo)
			8'd2: dim = (yr[1:0] == 2'b00) ? 8'd29 : 8'd28;
			8'd4, 8'd6, 8'd9, 8'd11: dim = 8'd30;
			default: dim = 8'd31;
		endcase
		if (s == 8'd60) begin
			s = 8'h00;
			m = 8'(m + 8'd1);
		end
		if (m == 8'd60) begin
			m = 8'h00;
			h = 8'(h + 8'd1);
		end
		if (h == 8'd24) begin
			h = 8'h00;
			wd = (wd == 8'd7) ? 8'd1 : 8'(wd + 8'd1);
			md = 8'(md + 8'd1);
		end
		if (md > dim) begin
			md = 8'd1;
			mo = 8'(mo + 8'd1);
		end
		if (mo == 8'd13) begin
			mo = 8'd1;
			yr = (yr == 8'd99) ? 8'h00 : 8'(yr + 8'd1);
		end
		if (t.h24_mode) begin
			t.nxt.hour = enc(h, t.bin_mode);
		end else begin
			h12 = 8'(h % 8'd12);
			if (h12 == 8'h00) begin
				h12 = 8'd12;
			end
			hx = enc(h12, t.bin_mode);
			t.nxt.hour = {h >= 8'd12, hx[6:0]};
		end
		t.nxt.sec = enc(s, t.bin_mode);
		t.nxt.min = enc(m, t.bin_mode);
		t.nxt.wday = enc(wd, t.bin_mode);
		t.nxt.mday = enc(md, t.bin_mode);
		t.nxt.mon = enc(mo, t.bin_mode);
		t.nxt.year = enc(yr, t.bin_mode);
	end
endmodule : ruc_time_adv

// ---- rtl/ruc_time_if.sv ----
`timescale 1ns/1ps
interface ruc_time_if;
	ruc_pkg::ruc_time_t cur;
	ruc_pkg::ruc_time_t nxt;
	logic bin_mode;
	logic h24_mode;
	modport core (output cur, output bin_mode, output h24_mode, input nxt);
	modport adv (input cur, input bin_mode, input h24_mode, output nxt);
endinterface : ruc_time_if

// ---- sim/rtc_update_alarm_periodic_core_test.sv ----
`timescale 1ns/1ps
module rtc_update_alarm_periodic_core_test;
	logic core_clk, rst_n, ad_oe, square_out, irq_n_out, irq_n_oe;
	logic osc_tick = 1'b0;
	logic osc_fast = 1'b0;
	logic addr_strobe, cs_n, rd_n, wr_n, oe;
	logic [7:0] ad_in, ad_out, v;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	int k;
	logic [7:0] wdat [10] = '{8'h59, 8'hc0, 8'h59, 8'hc0, 8'h23, 8'hc0, 8'h07, 8'h31, 8'h12, 8'h99};
	logic [7:0] rdat [10] = '{8'h00, 8'hc0, 8'h00, 8'hc0, 8'h00, 8'hc0, 8'h01, 8'h01, 8'h01, 8'h00};
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	ruc_core dut (.core_clk(core_clk), .rst_n(rst_n), .osc_tick(osc_tick), .ad_in(ad_in),
		.ad_out(ad_out), .ad_oe(ad_oe), .addr_strobe(addr_strobe), .cs_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .square_out(square_out), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
	ruc_host_model host (.core_clk(core_clk), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in),
		.addr_strobe(addr_strobe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n));
	// ---------------------------------------------
	// time base and hang guard
	// ---------------------------------------------
	// slow phase pulses every other cycle for the rate checks; the fast phase
	// ticks every cycle so that two update cycles fit inside the run
	always @(negedge core_clk) osc_tick <= osc_fast || !osc_tick;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 90000) begin
			error_cnt++;
			end_sim();
		end
	end
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
		host.rd(a, v, oe);
		check(v, exp);
	endtask : rchk
	task automatic rises(input int n, output int r);
		logic p;
		r = 0;
		#1;
		p = square_out;
		repeat (n) begin
			@(posedge core_clk);
			#1;
			if (square_out === 1'b1 && p === 1'b0) r++;
			p = square_out;
		end
	endtask : rises
	task automatic end_sim();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		rst_n = 1'b0;
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		check({7'h00, irq_n_oe}, 8'h00);
		check({7'h00, irq_n_out}, 8'h00);
		rchk(ruc_pkg::ADDR_CTRL_B, 8'h00);
		rchk(ruc_pkg::ADDR_CTRL_C, 8'h00);
		rchk(ruc_pkg::ADDR_CTRL_D, 8'h80);
		check({7'h00, oe}, 8'h01);
		host.wr(7'h0e, 8'ha5);
		host.wr(7'h7f, 8'h5a);
		rchk(7'h0e, 8'ha5);
		rchk(7'h7f, 8'h5a);
		host.wr(ruc_pkg::ADDR_CTRL_C, 8'hff);
		rchk(ruc_pkg::ADDR_CTRL_C, 8'h00);
		host.wr(ruc_pkg::ADDR_CTRL_A, 8'h83);
		rchk(ruc_pkg::ADDR_CTRL_A, 8'h03);
		rises(64, k);
		check(8'(k), 8'h00);
		check({7'h00, square_out}, 8'h00);
		// square enabled, periodic request left off
		host.wr(ruc_pkg::ADDR_CTRL_B, 8'h08);
		for (int r = 0; r < 11; r++) begin
			host.wr(ruc_pkg::ADDR_CTRL_A, 8'(r));
			repeat (2) @(posedge core_clk);
			rises(r == 0 ? 64 : 2 * (r == 1 ? 256 : r == 2 ? 512 : (1 << r)), k);
			check(8'(k), r == 0 ? 8'h00 : 8'h02);
		end
		check({7'h00, irq_n_oe}, 8'h00);
		rchk(ruc_pkg::ADDR_CTRL_C, 8'h40);
		host.wr(ruc_pkg::ADDR_CTRL_A, 8'h03);
		host.wr(ruc_pkg::ADDR_CTRL_B, 8'h48);
		repeat (16) @(posedge core_clk);
		#1;
		check({7'h00, irq_n_oe}, 8'h01);
		host.wr(ruc_pkg::ADDR_CTRL_A, 8'h00);
		rchk(ruc_pkg::ADDR_CTRL_C, 8'hc0);
		repeat (2) @(posedge core_clk);
		#1;
		check({7'h00, irq_n_oe}, 8'h00);
		rchk(ruc_pkg::ADDR_CTRL_C, 8'h00);
		osc_fast = 1'b1;
		// freeze, 24-hour bcd, load last second of the century, unfreeze
		host.wr(ruc_pkg::ADDR_CTRL_B, 8'h82);
		for (int i = 0; i < 10; i++) host.wr(7'(i), wdat[i]);
		host.wr(ruc_pkg::ADDR_CTRL_B, 8'h32);
		v = 8'h00;
		for (int i = 0; i < 20000 && v[7] !== 1'b1; i++) host.rd(ruc_pkg::ADDR_CTRL_A, v, oe);
		check({7'h00, v[7]}, 8'h01);
		check({7'h00, irq_n_oe}, 8'h00);
		for (int i = 0; i < 200 && irq_n_oe !== 1'b1; i++) @(posedge core_clk);
		check({7'h00, irq_n_oe}, 8'h01);
		rchk(ruc_pkg::ADDR_CTRL_C, 8'hb0);
		rchk(ruc_pkg::ADDR_CTRL_A, 8'h00);
		for (int i = 0; i < 10; i++) rchk(7'(i), rdat[i]);
		// frozen update: flags set, no request, host copy held
		host.wr(ruc_pkg::ADDR_CTRL_B, 8'h92);
		v = 8'h00;
		for (int i = 0; i < 20000 && v[4] !== 1'b1; i++) host.rd(ruc_pkg::ADDR_CTRL_C, v, oe);
		check(v, 8'h30);
		check({7'h00, irq_n_oe}, 8'h00);
		rchk(ruc_pkg::ADDR_SECONDS_COUNT, 8'h00);
		rchk(ruc_pkg::ADDR_CTRL_A, 8'h00);
		end_sim();
	end
endmodule : rtc_update_alarm_periodic_core_test

// ---- sim/ruc_host_model.sv ----
`timescale 1ns/1ps
module ruc_host_model (
	input wire logic core_clk,
	input wire logic [7:0] ad_out,
	input wire logic ad_oe,
	output logic [7:0] ad_in,
	output logic addr_strobe,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n
);
	// ---------------------------------------------
	// host bus cycles, all driven on falling edges
	// ---------------------------------------------
	initial begin
		ad_in = 8'h00;
		addr_strobe = 1'b0;
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
	end
	task automatic addr_phase(input logic [6:0] a);
		@(negedge core_clk);
		addr_strobe = 1'b1;
		ad_in = {1'b0, a};
		@(negedge core_clk);
		addr_strobe = 1'b0;
		@(negedge core_clk);
	endtask : addr_phase
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		addr_phase(a);
		cs_n = 1'b0;
		wr_n = 1'b0;
		ad_in = d;
		@(negedge core_clk);
		wr_n = 1'b1;
		@(negedge core_clk);
		cs_n = 1'b1;
		// released bus: inverse of last value so a stale copy cannot match
		ad_in = ~d;
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic oe);
		addr_phase(a);
		ad_in = ~ad_in;
		cs_n = 1'b0;
		rd_n = 1'b0;
		// read data is registered: take it mid-cycle, once the rising edge has settled
		@(negedge core_clk);
		d = ad_out;
		oe = ad_oe;
		rd_n = 1'b1;
		cs_n = 1'b1;
	endtask : rd
endmodule : ruc_host_model
